// ### hw/condition_code_unit.v
// Accumulator pair, condition flags and stop control behind an AXI4-Lite register slave.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ccu_map.vh"

module condition_code_unit (
   input  wire        aclk,                 // Clock, 250 MHz
   input  wire        aresetn,              // Synchronous reset, active low
   input  wire [7:0]  awaddr,               // Write address
   input  wire [2:0]  awprot,               // Write protection, unused
   input  wire        awvalid,              // Write address valid
   output wire        awready,              // Write address ready
   input  wire [31:0] wdata,                // Write data
   input  wire [3:0]  wstrb,                // Write byte strobes
   input  wire        wvalid,               // Write data valid
   output wire        wready,               // Write data ready
   output wire [1:0]  bresp,                // Write response
   output wire        bvalid,               // Write response valid
   input  wire        bready,               // Write response ready
   input  wire [7:0]  araddr,               // Read address
   input  wire [2:0]  arprot,               // Read protection, unused
   input  wire        arvalid,              // Read address valid
   output wire        arready,              // Read address ready
   output wire [31:0] rdata,                // Read data
   output wire [1:0]  rresp,                // Read response
   output wire        rvalid,               // Read data valid
   input  wire        rready,               // Read data ready
   output wire        stopped,              // Program execution stopped
   output wire        jump_if_zero,         // Zero jump would be taken
   output wire        jump_if_nonzero,      // Nonzero jump would be taken
   output wire        jump_if_positive,     // Positive jump would be taken
   output wire        jump_if_minus,        // Minus jump would be taken
   output wire        jump_on_range_error,  // Range error jump would be taken
   output wire        jump_if_logic_true    // Logic true jump would be taken
);

   // Mapped word offsets answer OKAY; anything else answers SLVERR.
   function is_mapped;
      input [7:0] a;
      begin
         case (a)
            `CCU_OFS_CMD,
            `CCU_OFS_PRI,
            `CCU_OFS_SEC,
            `CCU_OFS_OPND,
            `CCU_OFS_STAT,
            `CCU_OFS_RUN:
               is_mapped = 1'b1;
            default:
               is_mapped = 1'b0;
         endcase
      end
   endfunction

   // Byte-lane merge for the 16-bit registers.
   function [15:0] merge16;
      input [15:0] old;
      input [15:0] dat;
      input [1:0]  strb;
      begin
         merge16[7:0]  = strb[0] ? dat[7:0]  : old[7:0];
         merge16[15:8] = strb[1] ? dat[15:8] : old[15:8];
      end
   endfunction

   // Bus side state.
   reg        awready_q;
   reg        wready_q;
   reg        aw_got_q;
   reg        w_got_q;
   reg [7:0]  waddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   reg        bvalid_q;
   reg [1:0]  bresp_q;
   reg        arready_q;
   reg        rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0]  rresp_q;

   // Processor state.
   reg [15:0] pri_q;
   reg [15:0] sec_q;
   reg [15:0] opnd_q;
   reg [7:0]  last_cmd_q;
   reg        cond_low_q;
   reg        cond_high_q;
   reg        range_q;
   reg        lrb_q;
   reg        stopped_q;

   wire        commit;
   wire        exec;
   wire        run_req;
   wire [15:0] alu_pri;
   wire [15:0] alu_sec;
   wire [1:0]  alu_cc;
   wire        alu_ov;
   wire        alu_lrb;
   wire        alu_we_acc;
   wire        alu_we_cc;
   wire        alu_we_ov;
   wire        alu_we_lrb;
   wire        alu_halt;
   wire        jz_w;
   wire        jnz_w;
   wire        jp_w;
   wire        jm_w;
   wire        jo_w;
   wire        jc_w;
   reg  [31:0] stat_word;

   // A write is committed once both its address and its data are held.
   assign commit  = aw_got_q && w_got_q;

   // Commands are dropped silently while stopped; the write still answers OKAY.
   assign exec    = commit && (waddr_q == `CCU_OFS_CMD) && wstrb_q[0] && !stopped_q;

   assign run_req = commit && (waddr_q == `CCU_OFS_RUN) && wstrb_q[0] &&
                    (wdata_q[`CCU_RUN_SELECTOR] || wdata_q[`CCU_RUN_PROGRAM]);

   cc_alu u_alu (
      .op     (wdata_q[`CCU_CMD_OP_LSB +: 4]),
      .rel    (wdata_q[`CCU_CMD_REL_LSB +: 3]),
      .pri    (pri_q),
      .sec    (sec_q),
      .opnd   (opnd_q),
      .pri_o  (alu_pri),
      .sec_o  (alu_sec),
      .cc_o   (alu_cc),
      .ov_o   (alu_ov),
      .lrb_o  (alu_lrb),
      .we_acc (alu_we_acc),
      .we_cc  (alu_we_cc),
      .we_ov  (alu_we_ov),
      .we_lrb (alu_we_lrb),
      .halt_o (alu_halt)
   );

   jump_decode u_jump (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cc      ({cond_high_q, cond_low_q}),
      .ov      (range_q),
      .lrb     (lrb_q),
      .jz_q    (jz_w),
      .jnz_q   (jnz_w),
      .jp_q    (jp_w),
      .jm_q    (jm_w),
      .jo_q    (jo_w),
      .jc_q    (jc_w)
   );

   // Write address and data channels, taken in either order.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         waddr_q   <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `CCU_RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready_q)
         begin
            awready_q <= 1'b0;
            aw_got_q  <= 1'b1;
            waddr_q   <= awaddr;
         end
         if (wvalid && wready_q)
         begin
            wready_q <= 1'b0;
            w_got_q  <= 1'b1;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
         end
         if (commit)
         begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(waddr_q) ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
         end
         // Ready stays low until the response leaves, so one write is under way at most.
         if (bvalid_q && bready)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Status word seen by software.
   always @*
   begin
      stat_word = 32'h00000000;
      stat_word[`CCU_STAT_LOW]   = cond_low_q;
      stat_word[`CCU_STAT_HIGH]  = cond_high_q;
      stat_word[`CCU_STAT_RANGE] = range_q;
      stat_word[`CCU_STAT_LOGIC] = lrb_q;
      stat_word[`CCU_STAT_STOP]  = stopped_q;
      stat_word[`CCU_STAT_JZ +: 6] = {jc_w, jo_w, jm_w, jp_w, jnz_w, jz_w};
   end

   // Read channel: data is answered one cycle after the address is taken.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `CCU_RESP_OKAY;
      end
      else
      begin
         if (arvalid && arready_q)
         begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= is_mapped(araddr) ? `CCU_RESP_OKAY : `CCU_RESP_SLVERR;
            case (araddr)
               `CCU_OFS_CMD:  rdata_q <= {24'h000000, last_cmd_q};
               `CCU_OFS_PRI:  rdata_q <= {16'h0000, pri_q};
               `CCU_OFS_SEC:  rdata_q <= {16'h0000, sec_q};
               `CCU_OFS_OPND: rdata_q <= {16'h0000, opnd_q};
               `CCU_OFS_STAT: rdata_q <= stat_word;
               default:       rdata_q <= 32'h00000000;
            endcase
         end
         if (rvalid_q && rready)
         begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // Accumulators and operand register: 16-bit words loaded by software or the datapath.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pri_q      <= `CCU_ACC_RST;
         sec_q      <= `CCU_ACC_RST;
         opnd_q     <= `CCU_ACC_RST;
         last_cmd_q <= 8'h00;
      end
      else
      begin
         if (exec)
            last_cmd_q <= wdata_q[7:0];
         if (exec && alu_we_acc)
         begin
            pri_q <= alu_pri;
            sec_q <= alu_sec;
         end
         if (commit && (waddr_q == `CCU_OFS_PRI))
            pri_q <= merge16(pri_q, wdata_q[15:0], wstrb_q[1:0]);
         if (commit && (waddr_q == `CCU_OFS_SEC))
            sec_q <= merge16(sec_q, wdata_q[15:0], wstrb_q[1:0]);
         if (commit && (waddr_q == `CCU_OFS_OPND))
            opnd_q <= merge16(opnd_q, wdata_q[15:0], wstrb_q[1:0]);
      end
   end

   // Flags change only when the executed operation defines them.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cond_low_q  <= 1'b0;
         cond_high_q <= 1'b0;
         range_q     <= 1'b0;
         lrb_q       <= 1'b0;
      end
      else if (exec)
      begin
         if (alu_we_cc)
         begin
            cond_high_q <= alu_cc[1];
            cond_low_q  <= alu_cc[0];
         end
         if (alu_we_ov)
            range_q <= alu_ov;
         if (alu_we_lrb)
            lrb_q <= alu_lrb;
      end
   end

   // Stop control: halting is taken at once, and only a run request or reset clears it.
   always @(posedge aclk)
   begin
      if (!aresetn)
         stopped_q <= 1'b0;
      else if (exec && alu_halt)
         stopped_q <= 1'b1;
      else if (run_req)
         stopped_q <= 1'b0;
   end

   assign awready             = awready_q;
   assign wready              = wready_q;
   assign bresp               = bresp_q;
   assign bvalid              = bvalid_q;
   assign arready             = arready_q;
   assign rdata               = rdata_q;
   assign rresp               = rresp_q;
   assign rvalid              = rvalid_q;
   assign stopped             = stopped_q;
   assign jump_if_zero        = jz_w;
   assign jump_if_nonzero     = jnz_w;
   assign jump_if_positive    = jp_w;
   assign jump_if_minus       = jm_w;
   assign jump_on_range_error = jo_w;
   assign jump_if_logic_true  = jc_w;

endmodule // condition_code_unit

`default_nettype wire

// ### hw/ccu_map.vh
// Register offsets, command encodings and field positions of the condition code unit.
`ifndef CCU_MAP_VH
`define CCU_MAP_VH

`define CCU_ADDR_W       8
`define CCU_OFS_CMD      8'h00
`define CCU_OFS_PRI      8'h04
`define CCU_OFS_SEC      8'h08
`define CCU_OFS_OPND     8'h0c
`define CCU_OFS_STAT     8'h10
`define CCU_OFS_RUN      8'h14

`define CCU_OP_NOP       4'h0
`define CCU_OP_SWAP      4'h1
`define CCU_OP_HALT      4'h2
`define CCU_OP_CMP       4'h3
`define CCU_OP_ADD       4'h4
`define CCU_OP_SUB       4'h5
`define CCU_OP_ADDK      4'h6
`define CCU_OP_AND       4'h7
`define CCU_OP_OR        4'h8
`define CCU_OP_XOR       4'h9
`define CCU_OP_SHL       4'ha
`define CCU_OP_SHR       4'hb
`define CCU_OP_TWOS      4'hc

`define CCU_REL_EQ       3'h0
`define CCU_REL_NE       3'h1
`define CCU_REL_GT       3'h2
`define CCU_REL_LT       3'h3
`define CCU_REL_GE       3'h4
`define CCU_REL_LE       3'h5

`define CCU_CMD_OP_LSB   0
`define CCU_CMD_REL_LSB  4
`define CCU_RUN_SELECTOR 0
`define CCU_RUN_PROGRAM  1

`define CCU_STAT_LOW     0
`define CCU_STAT_HIGH    1
`define CCU_STAT_RANGE   2
`define CCU_STAT_LOGIC   3
`define CCU_STAT_STOP    4
`define CCU_STAT_JZ      5

`define CCU_ACC_RST      16'h0000
`define CCU_MIN_WORD     16'h8000
`define CCU_RESP_OKAY    2'b00
`define CCU_RESP_SLVERR  2'b10

`endif

// ### hw/cc_alu.v
// Combinational word datapath that computes accumulator results and new condition flags.
`timescale 1ns/1ps
`default_nettype none
`include "ccu_map.vh"

module cc_alu (
   input  wire [3:0]  op,        // Operation code
   input  wire [2:0]  rel,       // Comparison relation
   input  wire [15:0] pri,       // Primary accumulator
   input  wire [15:0] sec,       // Secondary accumulator
   input  wire [15:0] opnd,      // Constant or shift count
   output reg  [15:0] pri_o,     // New primary accumulator
   output reg  [15:0] sec_o,     // New secondary accumulator
   output reg  [1:0]  cc_o,      // New {high, low} condition bits
   output reg         ov_o,      // New range flag
   output reg         lrb_o,     // New logic result bit
   output reg         we_acc,    // Accumulators update
   output reg         we_cc,     // Condition bits update
   output reg         we_ov,     // Range flag updates
   output reg         we_lrb,    // Logic result bit updates
   output reg         halt_o     // Enter stopped mode
);

   // Zero gives 0/0, negative gives 0/1, positive gives 1/0.
   function [1:0] cc_of;
      input [15:0] w;
      begin
         if (w == 16'h0000)
            cc_of = 2'b00;
         else if (w[15])
            cc_of = 2'b01;
         else
            cc_of = 2'b10;
      end
   endfunction

   reg [16:0] wide;
   reg        lt;

   always @*
   begin
      pri_o  = pri;
      sec_o  = sec;
      cc_o   = 2'b00;
      ov_o   = 1'b0;
      lrb_o  = 1'b0;
      we_acc = 1'b0;
      we_cc  = 1'b0;
      we_ov  = 1'b0;
      we_lrb = 1'b0;
      halt_o = 1'b0;
      wide   = 17'h00000;
      lt     = $signed(sec) < $signed(pri);
      case (op)
         `CCU_OP_SWAP:
         begin
            pri_o  = sec;
            sec_o  = pri;
            we_acc = 1'b1;
         end
         `CCU_OP_HALT:
            halt_o = 1'b1;
         `CCU_OP_CMP:
         begin
            cc_o   = (sec == pri) ? 2'b00 : (lt ? 2'b01 : 2'b10);
            we_cc  = 1'b1;
            we_lrb = 1'b1;
            case (rel)
               `CCU_REL_EQ: lrb_o = (sec == pri);
               `CCU_REL_NE: lrb_o = (sec != pri);
               `CCU_REL_GT: lrb_o = !lt && (sec != pri);
               `CCU_REL_LT: lrb_o = lt;
               `CCU_REL_GE: lrb_o = !lt;
               `CCU_REL_LE: lrb_o = lt || (sec == pri);
               default:     lrb_o = 1'b0;
            endcase
         end
         `CCU_OP_ADD, `CCU_OP_SUB:
         begin
            // The 17-bit sum holds every true result, down to minus 65536.
            if (op == `CCU_OP_ADD)
               wide = {sec[15], sec} + {pri[15], pri};
            else
               wide = {sec[15], sec} - {pri[15], pri};
            pri_o  = wide[15:0];
            cc_o   = cc_of(wide[15:0]);
            ov_o   = wide[16] ^ wide[15];
            we_acc = 1'b1;
            we_cc  = 1'b1;
            we_ov  = 1'b1;
         end
         `CCU_OP_ADDK:
         begin
            pri_o  = pri + opnd;
            we_acc = 1'b1;
         end
         `CCU_OP_AND, `CCU_OP_OR, `CCU_OP_XOR:
         begin
            if (op == `CCU_OP_AND)
               pri_o = pri & sec;
            else if (op == `CCU_OP_OR)
               pri_o = pri | sec;
            else
               pri_o = pri ^ sec;
            cc_o   = (pri_o == 16'h0000) ? 2'b00 : 2'b10;
            we_acc = 1'b1;
            we_cc  = 1'b1;
         end
         `CCU_OP_SHL, `CCU_OP_SHR:
         begin
            // A count of zero shifts nothing, so no bit leaves and the flags stay.
            if (op == `CCU_OP_SHL)
            begin
               wide  = {1'b0, pri} << opnd[3:0];
               pri_o = wide[15:0];
               cc_o  = {wide[16], 1'b0};
            end
            else
            begin
               wide  = {pri, 1'b0} >> opnd[3:0];
               pri_o = wide[16:1];
               cc_o  = {wide[0], 1'b0};
            end
            we_acc = 1'b1;
            we_cc  = (opnd[3:0] != 4'h0);
         end
         `CCU_OP_TWOS:
         begin
            pri_o  = 16'h0000 - pri;
            cc_o   = cc_of(pri_o);
            ov_o   = (pri == `CCU_MIN_WORD);
            we_acc = 1'b1;
            we_cc  = 1'b1;
            we_ov  = 1'b1;
         end
         default:
            we_acc = 1'b0;
      endcase
   end

endmodule // cc_alu

`default_nettype wire

// ### hw/jump_decode.v
// Registered decoding of the condition flags into conditional jump enables.
`timescale 1ns/1ps
`default_nettype none

module jump_decode (
   input  wire       aclk,     // Clock
   input  wire       aresetn,  // Synchronous reset, active low
   input  wire [1:0] cc,       // {high, low} condition bits
   input  wire       ov,       // Range flag
   input  wire       lrb,      // Logic result bit
   output reg        jz_q,     // Zero jump taken
   output reg        jnz_q,    // Nonzero jump taken
   output reg        jp_q,     // Positive jump taken
   output reg        jm_q,     // Minus jump taken
   output reg        jo_q,     // Range error jump taken
   output reg        jc_q      // Logic true jump taken
);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         jz_q  <= 1'b1;
         jnz_q <= 1'b0;
         jp_q  <= 1'b0;
         jm_q  <= 1'b0;
         jo_q  <= 1'b0;
         jc_q  <= 1'b0;
      end
      else
      begin
         jz_q  <= (cc == 2'b00);
         jnz_q <= (cc != 2'b00);
         jp_q  <= (cc == 2'b10);
         jm_q  <= (cc == 2'b01);
         jo_q  <= ov;
         jc_q  <= lrb;
      end
   end

endmodule // jump_decode

`default_nettype wire

// ### verif/ccu_checker_sva.sv
// Port assertions of the condition code unit.
`timescale 1ns/1ps
`default_nettype none
module ccu_checker (
   input wire logic aclk,                // Clock
   input wire logic aresetn,             // Synchronous reset, active low
   input wire logic awvalid,             // Write address valid
   input wire logic awready,             // Write address ready
   input wire logic wvalid,              // Write data valid
   input wire logic wready,              // Write data ready
   input wire logic bvalid,              // Write response valid
   input wire logic bready,              // Write response ready
   input wire logic stopped,             // Stopped mode
   input wire logic jump_if_zero,        // Zero jump
   input wire logic jump_if_nonzero,     // Nonzero jump
   input wire logic jump_if_positive,    // Positive jump
   input wire logic jump_if_minus,       // Minus jump
   input wire logic jump_on_range_error, // Range jump
   input wire logic jump_if_logic_true   // Logic jump
);
   logic       bv_q;
   logic       cm_q;
   wire  [5:0] jv = {jump_if_logic_true, jump_on_range_error, jump_if_minus,
                     jump_if_positive, jump_if_nonzero, jump_if_zero};
   // Jump outputs may move only in the cycle after a commit.
   always_ff @(posedge aclk) bv_q <= aresetn && bvalid;
   always_ff @(posedge aclk) cm_q <= aresetn && bvalid && !bv_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_both; awvalid && awready && wvalid && wready; endsequence
   sequence s_commit; $rose(bvalid); endsequence
   property p_jz; jump_if_zero != jump_if_nonzero; endproperty
   a_jz: assert property (p_jz) else $error("zero and nonzero jumps agree");
   property p_pm; !(jump_if_positive && jump_if_minus); endproperty
   a_pm: assert property (p_pm) else $error("positive and minus jumps both set");
   property p_pn; (jump_if_positive || jump_if_minus) |-> jump_if_nonzero; endproperty
   a_pn: assert property (p_pn) else $error("signed jump without nonzero jump");
   property p_jchg; !$stable(jv) |-> cm_q; endproperty
   a_jchg: assert property (p_jchg) else $error("jump outputs moved without a commit");
   property p_srise; $rose(stopped) |-> s_commit; endproperty
   a_srise: assert property (p_srise) else $error("stop entered outside a commit");
   property p_sfall; $fell(stopped) |-> s_commit; endproperty
   a_sfall: assert property (p_sfall) else $error("stop left by itself");
   property p_sfrz; stopped |=> $stable(jv); endproperty
   a_sfrz: assert property (p_sfrz) else $error("flags changed while stopped");
   property p_blat; s_both |-> ##1 !bvalid ##1 bvalid; endproperty
   a_blat: assert property (p_blat) else $error("late or early write response");
   property p_bhold; bvalid |-> !awready && !wready; endproperty
   a_bhold: assert property (p_bhold) else $error("write taken while response pending");
endmodule // ccu_checker
bind condition_code_unit ccu_checker u_sva (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .stopped(stopped),
   .jump_if_zero(jump_if_zero), .jump_if_nonzero(jump_if_nonzero),
   .jump_if_positive(jump_if_positive), .jump_if_minus(jump_if_minus),
   .jump_on_range_error(jump_on_range_error), .jump_if_logic_true(jump_if_logic_true));
`default_nettype wire

// ### verif/ccu_master.sv
// Register bus master standing in for the instruction sequencer.
`timescale 1ns/1ps
`default_nettype none
module ccu_master (
   input  wire logic        aclk,    // Clock
   output logic      [7:0]  awaddr,  // Write address
   output logic             awvalid, // Write address valid
   input  wire logic        awready, // Write address ready
   output logic      [31:0] wdata,   // Write data
   output logic             wvalid,  // Write data valid
   input  wire logic        wready,  // Write data ready
   input  wire logic [1:0]  bresp,   // Write response
   input  wire logic        bvalid,  // Write response valid
   output logic             bready,  // Write response ready
   output logic      [7:0]  araddr,  // Read address
   output logic             arvalid, // Read address valid
   input  wire logic        arready, // Read address ready
   input  wire logic [31:0] rdata,   // Read data
   input  wire logic [1:0]  rresp,   // Read response
   input  wire logic        rvalid,  // Read data valid
   output logic             rready   // Read data ready
);
   initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      // Released payload is inverted so a late sampler cannot see stale data.
      awaddr <= ~a;
      wdata  <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      araddr <= ~a;
   endtask
endmodule // ccu_master
`default_nettype wire

// ### verif/test_condition_code_unit.sv
// Self-checking bench of the condition code unit.
`timescale 1ns/1ps
`default_nettype none
`include "ccu_map.vh"
module test_condition_code_unit;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   wire  [7:0]  awaddr, araddr;
   wire  [31:0] wdata, rdata;
   wire  [1:0]  bresp, rresp;
   wire         awvalid, awready, wvalid, wready, bvalid, bready;
   wire         arvalid, arready, rvalid, rready, stopped;
   wire  [5:0]  jmp;
   int          err_total = 0;
   int          total_checks = 0;
   logic [31:0] d;
   logic [1:0]  r;
   condition_code_unit uut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .stopped(stopped), .jump_if_zero(jmp[0]), .jump_if_nonzero(jmp[1]),
      .jump_if_positive(jmp[2]), .jump_if_minus(jmp[3]), .jump_on_range_error(jmp[4]),
      .jump_if_logic_true(jmp[5]));
   ccu_master m (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   initial forever #2 aclk = ~aclk;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] v);
      m.wr(a, v, r);
      chk("bresp", {30'h0, r}, 32'h0);
   endtask
   task automatic get(input string n, input logic [7:0] a, input logic [31:0] e);
      m.rd(a, d, r);
      chk(n, d, e);
      chk("rresp", {30'h0, r}, 32'h0);
   endtask
   // Status word expected from flags {logic, range, high, low} and stop.
   function automatic logic [31:0] st(input logic [3:0] f, input logic s);
      logic z;
      z = (f[1:0] == 2'b00);
      return {21'h0, f[3], f[2], f[1:0] == 2'b01, f[1:0] == 2'b10, !z, z, s, f};
   endfunction
   // v: cmd, sec, pri, operand, expected pri, flags.
   task automatic op(input logic [75:0] v);
      logic [31:0] e;
      logic [7:0]  c;
      logic [15:0] s, p, k, ep;
      {c, s, p, k, ep} = v[75:4];
      e = st(v[3:0], 1'b0);
      put(`CCU_OFS_SEC, {16'h0, s});
      put(`CCU_OFS_PRI, {16'h0, p});
      put(`CCU_OFS_OPND, {16'h0, k});
      put(`CCU_OFS_CMD, {24'h0, c});
      get("pri", `CCU_OFS_PRI, {16'h0, ep});
      get("sec", `CCU_OFS_SEC, {16'h0, (c[3:0] == `CCU_OP_SWAP) ? p : s});
      get("stat", `CCU_OFS_STAT, e);
      chk("jumps", {26'h0, jmp}, {26'h0, e[10:5]});
   endtask
   task automatic t_map;
      get("stat", `CCU_OFS_STAT, st(4'h0, 1'b0));
      get("pri", `CCU_OFS_PRI, 32'h0);
      m.wr(8'h40, 32'h1, r);
      chk("bresp", {30'h0, r}, {30'h0, `CCU_RESP_SLVERR});
      m.rd(8'h40, d, r);
      chk("rresp", {30'h0, r}, {30'h0, `CCU_RESP_SLVERR});
      chk("rdata", d, 32'h0);
      put(`CCU_OFS_STAT, 32'h7ff);
      get("stat", `CCU_OFS_STAT, st(4'h0, 1'b0));
      $display("test map done");
   endtask
   task automatic t_ops;
      op(76'h0500050005000000000);
      op(76'h048001ffff000080001);
      op(76'h047ffe000100007fff2);
      op(76'h058000000100007fff6);
      op(76'h047fff0001000080005);
      op(76'h0480008000000000004);
      op(76'h080f0000f000000ff06);
      op(76'h070f0f00f0000000004);
      op(76'h090001ffff0000fffe6);
      op(76'h030005000500000005c);
      op(76'h130003000500000005d);
      op(76'h23fffe0001000000015);
      op(76'h3300070002000000026);
      op(76'h430007000200000002e);
      op(76'h530005000500000005c);
      op(76'h061111001000050015c);
      op(76'h01abcd12340000abcdc);
      op(76'h0a0000800100010002e);
      op(76'h0b0000000100020000c);
      op(76'h0c0000800000008000d);
      op(76'h0c000000010000ffff9);
      op(76'h0c00000000000000008);
      op(76'h0c0000ffff00000001a);
      op(76'h000000000300000003a);
      op(76'h0d0000000300000003a);
      $display("test ops done");
   endtask
   task automatic t_halt;
      put(`CCU_OFS_CMD, {28'h0, `CCU_OP_HALT});
      chk("stopped", {31'h0, stopped}, 32'h1);
      put(`CCU_OFS_PRI, 32'h3);
      put(`CCU_OFS_CMD, {28'h0, `CCU_OP_TWOS});
      get("pri", `CCU_OFS_PRI, 32'h3);
      get("stat", `CCU_OFS_STAT, st(4'ha, 1'b1));
      repeat (20) @(posedge aclk);
      chk("stopped", {31'h0, stopped}, 32'h1);
      put(`CCU_OFS_RUN, 32'h1);
      chk("stopped", {31'h0, stopped}, 32'h0);
      put(`CCU_OFS_CMD, {28'h0, `CCU_OP_HALT});
      put(`CCU_OFS_RUN, 32'h2);
      chk("stopped", {31'h0, stopped}, 32'h0);
      $display("test halt done");
   endtask
   initial
   begin
      #20000;
      err_total++;
      report_and_stop;
   end
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_map;
      t_ops;
      t_halt;
      report_and_stop;
   end
endmodule // test_condition_code_unit
`default_nettype wire
